// [src/isb_burst_ctrl.sv]
// Decode-then-burst controller for a two-bank interleaved instruction SRAM
// Function
// [R1] Load strobe copies incoming address bits into upper counter regardless of count.
// [R2] Without load or count, upper counter bits hold their value.
// [R3] Counting ripples: bit toggles when carry-in and all lower bits high.
// [R4] Bank chip-enable latches decoded select on load, holds otherwise.
// [R5] One decode cycle, address loaded at its end, burst starts next clock.
// [R6] First word arrives two cycles after decode; three cycles overall.
// [R7] Later burst words come one per cycle, alternating banks.
// [R8] Processor drives request and address in cycle one, burst request late.
// [R9] Decode asserts instruction memory select when address is in range.
// [R10] Count enable when registered burst request meets burst-acknowledge state.
// [R11] Upper carry-in comes from the lower counter's carry-out.
`timescale 1ns/1ps
`default_nettype none
module isb_burst_ctrl #(
    parameter logic [31:0] MEM_BASE = 32'h0000_0000,
    parameter logic [31:0] MEM_MASK = 32'hFFFF_F000
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce_in,
    input wire isb_pkg::isb_req_s req,
    output logic instr_mem_sel,
    output logic instr_ready,
    output logic bank_oe_even,
    output logic bank_oe_odd,
    output isb_pkg::isb_mem_s mem
);
    import isb_pkg::*;

    // ==========================================
    // Decode
    // ==========================================
    // Address lies inside this instruction memory
    function automatic logic in_range(input logic [31:0] a);
        return (a & MEM_MASK) == (MEM_BASE & MEM_MASK);
    endfunction

    logic decode_hit;
    // Combinational select seen during the decode cycle, see [R9]
    assign decode_hit = req.instr_fetch_req && in_range(req.addr);

    // ==========================================
    // Sequencer
    // ==========================================
    isb_state_e state_ff;
    isb_state_e nxt_state_ff;
    logic instr_burst_ack_ff;
    logic nxt_instr_burst_ack_ff;
    logic burst_req_d_ff;
    logic nxt_burst_req_d_ff;
    logic sel_ff;
    logic nxt_sel_ff;
    logic ready_ff;
    logic nxt_ready_ff;
    logic oe_even_ff;
    logic nxt_oe_even_ff;
    logic oe_odd_ff;
    logic nxt_oe_odd_ff;
    logic [LOWER_W-1:0] lower_ff;
    logic [LOWER_W-1:0] nxt_lower_ff;

    logic addr_load_strobe;
    logic addr_advance_en;
    logic upper_carry_in;

    // Load at the end of the decode cycle while idle, see [R5] [R8]
    assign addr_load_strobe = decode_hit && (state_ff == ISB_IDLE);
    // Count on registered burst request in burst-ack state, see [R10]
    assign addr_advance_en = burst_req_d_ff && instr_burst_ack_ff;
    // Lower counter carry-out feeds the upper counter, see [R11]
    assign upper_carry_in = &lower_ff;

    // Next-state and output computation
    always_comb begin
        nxt_state_ff = state_ff;
        nxt_instr_burst_ack_ff = instr_burst_ack_ff;
        nxt_burst_req_d_ff = req.instr_burst_req;
        nxt_sel_ff = decode_hit;
        nxt_lower_ff = lower_ff;
        unique case (state_ff)
            ISB_IDLE: begin
                if (addr_load_strobe) begin
                    nxt_state_ff = ISB_ACCESS; // see [R5]
                end
            end
            ISB_ACCESS: begin
                // First bank access occupies this cycle and the next, see [R6]
                nxt_state_ff = ISB_BURST;
                nxt_instr_burst_ack_ff = 1'b1;
            end
            ISB_BURST: begin
                if (!burst_req_d_ff) begin
                    if (!req.instr_burst_req) begin
                        nxt_state_ff = ISB_IDLE;
                        nxt_instr_burst_ack_ff = 1'b0;
                    end
                end
            end
            default: begin
                nxt_state_ff = ISB_IDLE;
            end
        endcase
        // Lower counter loads with the address and steps on count
        if (addr_load_strobe) begin
            nxt_lower_ff = req.addr[LOWER_LSB +: LOWER_W];
        end else if (addr_advance_en) begin
            nxt_lower_ff = lower_ff + 3'h1;
        end
        // Ready once the first access completes, then one word per cycle, see [R6] [R7]
        // Every counter step presents a fresh word, so no counted word goes unannounced
        nxt_ready_ff = (state_ff == ISB_ACCESS) || addr_advance_en;
        // Bank enables follow the word address parity, alternating, see [R7]
        nxt_oe_even_ff = nxt_ready_ff && !nxt_lower_ff[0];
        nxt_oe_odd_ff = nxt_ready_ff && nxt_lower_ff[0];
    end

    // Sequencer registers
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_ff <= ISB_IDLE;
            instr_burst_ack_ff <= 1'b0;
            burst_req_d_ff <= 1'b0;
            sel_ff <= 1'b0;
            ready_ff <= 1'b0;
            oe_even_ff <= 1'b0;
            oe_odd_ff <= 1'b0;
            lower_ff <= LOWER_RST;
        end else if (ce_in) begin
            state_ff <= nxt_state_ff;
            instr_burst_ack_ff <= nxt_instr_burst_ack_ff;
            burst_req_d_ff <= nxt_burst_req_d_ff;
            sel_ff <= nxt_sel_ff;
            ready_ff <= nxt_ready_ff;
            oe_even_ff <= nxt_oe_even_ff;
            oe_odd_ff <= nxt_oe_odd_ff;
            lower_ff <= nxt_lower_ff;
        end
    end

    // ==========================================
    // Upper counter
    // ==========================================
    // Upper address bits and bank chip-enable, see [R1] [R2] [R3] [R4]
    isb_upper_counter u_upper (
        .mclk(mclk),
        .rst(rst),
        .ce_in(ce_in),
        .addr_load_strobe(addr_load_strobe),
        .addr_advance_en(addr_advance_en),
        .upper_carry_in(upper_carry_in),
        .decoded_mem_sel(decode_hit),
        .addr_in(req.addr[UPPER_LSB +: UPPER_W]),
        .upper_q(mem.upper),
        .bank_ce(mem.bank_ce)
    );

    // Registered outputs
    assign mem.lower = lower_ff;
    assign instr_mem_sel = sel_ff;
    assign instr_ready = ready_ff;
    assign bank_oe_even = oe_even_ff;
    assign bank_oe_odd = oe_odd_ff;
endmodule // isb_burst_ctrl
`default_nettype wire

// [src/isb_pkg.sv]
// Package for the interleaved SRAM burst address block: constants, states and carriers
package isb_pkg;
    // Upper counter width (address bits five to nine)
    localparam int UPPER_W = 5;
    // Lower counter width (address bits two to four)
    localparam int LOWER_W = 3;
    // Position of the upper counter's lowest bit in the word address
    localparam int UPPER_LSB = 5;
    // Position of the lower counter's lowest bit in the word address
    localparam int LOWER_LSB = 2;
    // Reset values
    localparam logic [UPPER_W-1:0] UPPER_RST = 5'h00;
    localparam logic [LOWER_W-1:0] LOWER_RST = 3'h0;
    localparam logic CE_RST = 1'h0;
    // Cycles from end of decode to first word, and total initial access
    localparam int FIRST_WORD_CYC = 2;
    localparam int INITIAL_ACCESS_CYC = 3;
    // Cycles per later burst word
    localparam int BURST_WORD_CYC = 1;

    // Access sequencer states
    typedef enum logic [1:0] {
        ISB_IDLE = 2'b00,
        ISB_ACCESS = 2'b01,
        ISB_BURST = 2'b10
    } isb_state_e;

    // Processor request group
    typedef struct packed {
        logic instr_fetch_req;
        logic instr_burst_req;
        logic [31:0] addr;
    } isb_req_s;

    // Memory side address group
    typedef struct packed {
        logic [UPPER_W-1:0] upper;
        logic [LOWER_W-1:0] lower;
        logic bank_ce;
    } isb_mem_s;
endpackage

// [src/isb_upper_counter.sv]
// Upper address counter bits with the bank chip-enable latch
`timescale 1ns/1ps
`default_nettype none
module isb_upper_counter (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce_in,
    input wire logic addr_load_strobe,
    input wire logic addr_advance_en,
    input wire logic upper_carry_in,
    input wire logic decoded_mem_sel,
    input wire logic [isb_pkg::UPPER_W-1:0] addr_in,
    output logic [isb_pkg::UPPER_W-1:0] upper_q,
    output logic bank_ce
);
    import isb_pkg::*;

    logic [UPPER_W-1:0] upper_ff;
    logic [UPPER_W-1:0] nxt_upper_ff;
    logic ce_ff;
    logic nxt_ce_ff;

    // Ripple chain: a bit toggles when carry-in and all lower bits are high
    always_comb begin
        logic chain;
        chain = upper_carry_in;
        nxt_upper_ff = upper_ff;
        nxt_ce_ff = ce_ff;
        if (addr_load_strobe) begin
            nxt_upper_ff = addr_in; // see [R1]
            nxt_ce_ff = decoded_mem_sel; // see [R4]
        end else if (addr_advance_en) begin
            for (int i = 0; i < UPPER_W; i++) begin
                nxt_upper_ff[i] = upper_ff[i] ^ chain; // see [R3]
                chain = chain & upper_ff[i];
            end
        end
        // Neither load nor count: hold, see [R2]
    end

    // State registers
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            upper_ff <= UPPER_RST;
            ce_ff <= CE_RST;
        end else if (ce_in) begin
            upper_ff <= nxt_upper_ff;
            ce_ff <= nxt_ce_ff;
        end
    end

    assign upper_q = upper_ff;
    assign bank_ce = ce_ff;
endmodule // isb_upper_counter
`default_nettype wire

// [testbench/isb_burst_ctrl_asserts.sv]
// Port checker for the burst address controller
`timescale 1ns/1ps
`default_nettype none
module isb_burst_ctrl_chk (
    input wire logic mclk,
    input wire logic rst,
    input wire isb_pkg::isb_req_s req,
    input wire logic instr_mem_sel,
    input wire logic instr_ready,
    input wire logic bank_oe_even,
    input wire logic bank_oe_odd,
    input wire isb_pkg::isb_mem_s mem
);
    import isb_pkg::*;
    // ====================
    // Relations at the ports
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    load_a: assert property ($rose(instr_mem_sel) |-> mem.upper == $past(req.addr[9:5]))
        else $error("upper count not loaded");
    first_a: assert property ($rose(instr_mem_sel) |-> !instr_ready ##1 instr_ready)
        else $error("first word latency");
    sel_a: assert property ($rose(instr_mem_sel) |-> $past(req.instr_fetch_req))
        else $error("select without request");
    ce_a: assert property ($changed(mem.bank_ce) |-> $rose(instr_mem_sel))
        else $error("enable moved without load");
    hold_a:
        assert property (!instr_ready && !$past(instr_ready) |-> $stable(mem) || $rose(instr_mem_sel))
        else $error("counter moved while idle");
    carry_a:
        assert property ($changed(mem.upper) |-> $past(mem.lower) == 3'h7 || $rose(instr_mem_sel))
        else $error("upper moved without carry");
    par_a:
        assert property (instr_ready |-> bank_oe_odd == mem.lower[0] && bank_oe_even != mem.lower[0])
        else $error("bank enable parity");
    alt_a:
        assert property (instr_ready && $past(instr_ready) |-> mem.lower != $past(mem.lower))
        else $error("counter did not advance");
endmodule // isb_burst_ctrl_chk
`default_nettype wire

// [testbench/isb_burst_ctrl_tb_top.sv]
// Bench for the burst address controller
`timescale 1ns/1ps
`default_nettype none
module isb_burst_ctrl_tb_top;
    import isb_pkg::*;
    logic mclk, rst, instr_mem_sel, instr_ready, bank_oe_even, bank_oe_odd;
    isb_req_s req;
    isb_mem_s mem;
    int num_errors = 0, check_count = 0;
    logic ce = 1'h1;
    // ====================
    // Design, processor model, clock
    isb_burst_ctrl isb_burst_ctrl_inst (.mclk, .rst, .ce_in(ce), .req, .instr_mem_sel,
        .instr_ready, .bank_oe_even, .bank_oe_odd, .mem);
    isb_cpu_model isb_cpu_model_inst (.mclk, .req);
    initial begin
        mclk = 1'h0;
        forever #2 mclk = ~mclk;
    end
    // Compare and count
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t %h %h", $time, got, exp);
        end
    endtask
    // Counts, verdict, end of run
    task automatic print_verdict();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Burst through carry and wrap with a one-cycle suspension; each word checked
    task automatic s_burst();
        logic [7:0] w = 8'hFE;
        isb_cpu_model_inst.start(32'h0000_03F8);
        chk({instr_mem_sel, instr_ready, mem}, {2'h2, w, 1'h1});
        for (int i = 0; i < 12; i++) begin
            isb_cpu_model_inst.set_burst(i < 6 && i != 2);
            @(negedge mclk);
            if (instr_ready === 1'h1) begin
                chk({bank_oe_odd, mem[8:1]}, {w[0], w});
                w++;
            end
        end
        chk({instr_ready, w}, 16'h0004);
    endtask
    // Out-of-range request: no select, counter and enable untouched
    task automatic s_refuse();
        isb_mem_s m = mem;
        isb_cpu_model_inst.start(32'h0000_2000);
        chk({instr_mem_sel, instr_ready}, 16'h0000);
        repeat (3) @(negedge mclk);
        chk(mem, m);
    endtask
    // Clock enable low: an in-range request must leave all state frozen
    task automatic s_freeze();
        isb_mem_s m = mem;
        ce = 1'h0;
        isb_cpu_model_inst.start(32'h0000_0040);
        repeat (2) @(negedge mclk);
        chk({instr_mem_sel, instr_ready, mem}, {2'h0, m});
        ce = 1'h1;
    endtask
    // Reset, scenarios, verdict
    initial begin
        rst = 1'h1;
        repeat (8) @(negedge mclk);
        rst = 1'h0;
        s_burst();
        s_refuse();
        s_freeze();
        print_verdict();
    end
endmodule // isb_burst_ctrl_tb_top
bind isb_burst_ctrl isb_burst_ctrl_chk isb_burst_ctrl_chk_inst (.mclk, .rst, .req,
    .instr_mem_sel, .instr_ready, .bank_oe_even, .bank_oe_odd, .mem);
`default_nettype wire

// [testbench/isb_cpu_model.sv]
// Processor request model for the burst controller
`timescale 1ns/1ps
`default_nettype none
module isb_cpu_model (
    input wire logic mclk,
    output var isb_pkg::isb_req_s req
);
    import isb_pkg::*;
    // ====================
    // Request for one cycle with burst request; address goes stale after it
    initial req = '0;
    task automatic start(input logic [31:0] a);
        @(negedge mclk);
        req = {1'h1, 1'h1, a};
        @(negedge mclk);
        req.instr_fetch_req = 1'h0;
        req.addr = ~a;
    endtask
    // Burst request level for the coming edge
    task automatic set_burst(input logic b);
        req.instr_burst_req = b;
    endtask
endmodule // isb_cpu_model
`default_nettype wire
